// ==== imode_bank_reg.sv ====
// register holding one bank of sixteen channel mode pairs
`timescale 1ns/1ps
module imode_bank_reg
  import imode_pkg::*;
#(
  parameter logic [31:0] RESET_VAL = 32'h0000_0000,
  parameter logic [31:0] IMPL_MASK = 32'hFFFF_FFFF
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // write port
  input wire logic wr_en,
  input wire logic [3:0] wr_sel,
  input wire logic [31:0] wr_data,
  // stored value
  output logic [31:0] q
);

  logic [31:0] bank_r;
  logic [31:0] bank_nxt;

  always_comb
  begin
    bank_nxt = bank_r;
    for (int b = 0; b < 4; b++)
    begin
      if (wr_en && wr_sel[b])
        bank_nxt[8*b +: 8] = wr_data[8*b +: 8];
    end
    // absent bits never hold a one
    bank_nxt = bank_nxt & IMPL_MASK;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      bank_r <= RESET_VAL & IMPL_MASK;
    else
      bank_r <= bank_nxt;
  end

  assign q = bank_r;

endmodule

// ==== imode_cfg.sv ====
// input mode configuration bank: wishbone slave, per-channel mode outputs
`timescale 1ns/1ps

// ****************************************************************
// Overview of operation
// ****************************************************************
// Overview of operation
// - diff bit one selects differential sampling
// - sign bit one selects signed result
// - low register: channel n diff 2n+1, sign 2n
// - high register holds channels 16 to 31
// - all mode bits read/write except channels 19 to 31 in the small build, reset to zero
// - small build drops channels 19 to 31
module imode_cfg
  import imode_pkg::*;
#(
  parameter bit SMALL_PKG = 1'b0
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // per-channel settings to the converter core
  output logic [NUM_CHAN-1:0] chan_differential_sel,
  output logic [NUM_CHAN-1:0] chan_signed_result_sel,
  // conversion results from the core, formatted per channel
  input wire logic conv_valid,
  input wire conv_raw_t conv_raw,
  output chan_mode_t conv_mode,
  output logic res_valid,
  output conv_out_t res_out
);

  // ****************************************************************
  // bus decode
  // ****************************************************************
  bus_state_t bus_state_r;
  logic req;
  logic wr_low;
  logic wr_high;
  logic [31:0] low_q;
  logic [31:0] high_q;
  logic [31:0] rd_mux;
  logic [31:0] dat_o_r;
  logic [31:0] status_word;
  logic [5:0] diff_count;
  logic [5:0] sign_count;

  // one request per idle cycle; ack stands one cycle, then drops
  assign req = wb_cyc_i && wb_stb_i && (bus_state_r == BUS_IDLE);
  assign wr_low = req && wb_we_i && (wb_adr_i == OFS_MODE_LOW);
  assign wr_high = req && wb_we_i && (wb_adr_i == OFS_MODE_HIGH);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      bus_state_r <= BUS_IDLE;
    else
    begin
      case (bus_state_r)
        BUS_IDLE:
          if (req)
            bus_state_r <= BUS_ACK;
        BUS_ACK:
          bus_state_r <= BUS_IDLE;
        default:
          bus_state_r <= BUS_IDLE;
      endcase
    end
  end

  assign wb_ack_o = (bus_state_r == BUS_ACK);

  // ****************************************************************
  // mode registers
  // ****************************************************************
  imode_bank_reg #(
    .RESET_VAL(MODE_LOW_RESET),
    .IMPL_MASK(32'hFFFF_FFFF)
  ) u_low (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_low),
    .wr_sel(wb_sel_i),
    .wr_data(wb_dat_i),
    .q(low_q)
  );

  // absent bits in the small build are not stored and read as zero
  imode_bank_reg #(
    .RESET_VAL(MODE_HIGH_RESET),
    .IMPL_MASK(high_impl_mask(SMALL_PKG))
  ) u_high (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_high),
    .wr_sel(wb_sel_i),
    .wr_data(wb_dat_i),
    .q(high_q)
  );

  // ****************************************************************
  // per-channel fan-out
  // ****************************************************************
  always_comb
  begin
    for (int n = 0; n < CHAN_PER_REG; n++)
    begin
      chan_differential_sel[n] = low_q[2*n + DIFF_BIT_POS];
      chan_signed_result_sel[n] = low_q[2*n + SIGN_BIT_POS];
      chan_differential_sel[n + CHAN_PER_REG] = high_q[2*n + DIFF_BIT_POS];
      chan_signed_result_sel[n + CHAN_PER_REG] = high_q[2*n + SIGN_BIT_POS];
    end
  end

  // mode of the channel now converting, for the core's front end
  always_comb
  begin
    conv_mode.differential = chan_differential_sel[conv_raw.chan];
    conv_mode.signed_result = chan_signed_result_sel[conv_raw.chan];
  end

  // ****************************************************************
  // status word: count of differential and signed channels
  // ****************************************************************
  always_comb
  begin
    diff_count = 6'h00;
    sign_count = 6'h00;
    for (int n = 0; n < NUM_CHAN; n++)
    begin
      diff_count = diff_count + {5'h00, chan_differential_sel[n]};
      sign_count = sign_count + {5'h00, chan_signed_result_sel[n]};
    end
  end

  assign status_word = {15'h0000, SMALL_PKG, 2'b00, sign_count, 2'b00, diff_count};

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb
  begin
    case (wb_adr_i)
      OFS_MODE_LOW: rd_mux = low_q;
      OFS_MODE_HIGH: rd_mux = high_q;
      OFS_STATUS: rd_mux = status_word;
      default: rd_mux = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      dat_o_r <= 32'h0000_0000;
    else if (req && !wb_we_i)
      dat_o_r <= rd_mux;
  end

  assign wb_dat_o = dat_o_r;

  // ****************************************************************
  // result formatting
  // ****************************************************************
  imode_result_fmt u_fmt (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(conv_valid),
    .in_raw(conv_raw),
    .in_mode(conv_mode),
    .out_valid(res_valid),
    .out_res(res_out)
  );

endmodule

// ==== imode_cfg_checker.sv ====
// checker: bus answer, field map, reset and result format of the mode bank
`timescale 1ns/1ps
module imode_cfg_checker
  import imode_pkg::*;
#(
  parameter bit SMALL_PKG = 1'b0
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // channel settings and results
  input wire logic [NUM_CHAN-1:0] chan_differential_sel,
  input wire logic [NUM_CHAN-1:0] chan_signed_result_sel,
  input wire logic conv_valid,
  input wire conv_raw_t conv_raw,
  input wire chan_mode_t conv_mode,
  input wire logic res_valid,
  input wire conv_out_t res_out
);
  logic [31:0] exp_val_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // offset binary in, msb inverted and sign extended for signed channels
  always_ff @(posedge clk_sys)
  begin
    exp_val_r <= conv_mode.signed_result ?
      {{21{~conv_raw.raw[11]}}, conv_raw.raw[10:0]} : {20'h0_0000, conv_raw.raw};
  end

  // ****************
  // properties
  // ****************
  AST_ACK: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle pulse");
  AST_LOW_MAP: assert property (
    wb_ack_o && $past(wb_we_i && wb_adr_i == OFS_MODE_LOW && wb_sel_i == 4'hF)
    |-> {chan_differential_sel[14], chan_signed_result_sel[14]} == $past(wb_dat_i[29:28]))
    else $error("low register field map wrong");
  AST_HIGH_MAP: assert property (
    wb_ack_o && $past(wb_we_i && wb_adr_i == OFS_MODE_HIGH && wb_sel_i == 4'hF)
    |-> {chan_differential_sel[31], chan_signed_result_sel[31]}
    == (SMALL_PKG ? 2'h0 : $past(wb_dat_i[31:30])))
    else $error("high register field map wrong");
  AST_READ: assert property (
    wb_ack_o && $past(!wb_we_i && wb_adr_i == OFS_MODE_LOW)
    |-> wb_dat_o[1:0] == {chan_differential_sel[0], chan_signed_result_sel[0]})
    else $error("read data differs from settings");
  AST_RST: assert property (
    $fell(rst) |-> (chan_differential_sel | chan_signed_result_sel) == 32'h0000_0000)
    else $error("settings not cleared by reset");
  AST_DIFF: assert property (
    conv_mode.differential == chan_differential_sel[conv_raw.chan])
    else $error("differential mode not that of the channel");
  AST_SIGN: assert property (
    conv_mode.signed_result == chan_signed_result_sel[conv_raw.chan])
    else $error("sign mode not that of the channel");
  AST_SMALL: assert property (
    SMALL_PKG |-> (chan_differential_sel[31:19] | chan_signed_result_sel[31:19]) == 13'h0000)
    else $error("absent channels not zero");
  AST_RES: assert property (
    conv_valid |=> res_valid && res_out.value == exp_val_r)
    else $error("result format wrong");
endmodule

bind imode_cfg imode_cfg_checker #(.SMALL_PKG(SMALL_PKG)) u_chk (.clk_sys, .rst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .chan_differential_sel, .chan_signed_result_sel, .conv_valid, .conv_raw, .conv_mode,
  .res_valid, .res_out);

// ==== imode_cfg_test.sv ====
// self-checking bench for the input mode bank
`timescale 1ns/1ps
module imode_cfg_test
  import imode_pkg::*;
;
  logic clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, conv_valid, res_valid;
  logic [ADDR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, small_dat, rd;
  logic [NUM_CHAN-1:0] chan_differential_sel, chan_signed_result_sel;
  conv_raw_t conv_raw;
  chan_mode_t conv_mode;
  conv_out_t res_out;
  int failures, compares;

  imode_cfg u_dut (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .chan_differential_sel, .chan_signed_result_sel,
    .conv_valid, .conv_raw, .conv_mode, .res_valid, .res_out);
  // reduced build shares the bus so both answer in the same cycle
  imode_cfg #(.SMALL_PKG(1'b1)) u_dut_small (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o(small_dat), .wb_ack_o(),
    .chan_differential_sel(), .chan_signed_result_sel(), .conv_valid, .conv_raw,
    .conv_mode(), .res_valid(), .res_out());

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, adr, dat, 4'hF};
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1) @(posedge clk_sys);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask

  // mode is {differential, signed} as written for that channel
  task automatic conv(input logic [4:0] ch, input logic [11:0] raw, input logic [1:0] mode,
    input logic [31:0] exp);
    @(posedge clk_sys);
    conv_valid <= 1'b1;
    conv_raw <= {ch, raw};
    @(posedge clk_sys);
    conv_valid <= 1'b0;
    #1;
    check({res_valid, res_out.chan, res_out.is_signed, res_out.value, conv_mode},
      {1'b1, ch, mode[0], exp, mode});
  endtask

  task automatic stop_test;
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // hang guard: the sequence needs well under a hundred cycles
  initial
  begin
    repeat (600) @(posedge clk_sys);
    failures++;
    stop_test;
  end

  initial
  begin
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, conv_valid, conv_raw} = '0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    xfer(1'b0, OFS_MODE_LOW, 32'h0000_0000);
    check(rd, MODE_LOW_RESET);
    xfer(1'b0, OFS_MODE_HIGH, 32'h0000_0000);
    check(rd, MODE_HIGH_RESET);
    xfer(1'b1, OFS_MODE_LOW, 32'h5A5A_A5A5);
    check({chan_differential_sel[14], chan_signed_result_sel[14]}, 64'h1);
    check({chan_differential_sel[2], chan_signed_result_sel[2]}, 64'h2);
    xfer(1'b1, OFS_MODE_HIGH, 32'h4000_007F);
    check({chan_differential_sel[31], chan_signed_result_sel[31]}, 64'h1);
    xfer(1'b0, OFS_MODE_HIGH, 32'h0000_0000);
    check(rd, 32'h4000_007F);
    check(small_dat, 32'h0000_003F);
    xfer(1'b0, OFS_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0D0B);
    check(small_dat, 32'h0001_0B0B);
    xfer(1'b1, 4'hC, 32'hFFFF_FFFF);
    xfer(1'b0, 4'hC, 32'h0000_0000);
    check(rd, UNMAPPED_READ);
    xfer(1'b0, OFS_MODE_LOW, 32'h0000_0000);
    check(rd, 32'h5A5A_A5A5);
    conv(5'h0E, 12'h801, 2'b01, 32'h0000_0001);
    conv(5'h0E, 12'h7FF, 2'b01, 32'hFFFF_FFFF);
    conv(5'h02, 12'h801, 2'b10, 32'h0000_0801);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    check({chan_differential_sel, chan_signed_result_sel}, 64'h0);
    xfer(1'b0, OFS_MODE_LOW, 32'h0000_0000);
    check(rd, MODE_LOW_RESET);
    stop_test;
  end
endmodule

// ==== imode_pkg.sv ====
// package: register map, field layout and carrier types for the input mode bank
package imode_pkg;

  localparam int unsigned NUM_CHAN = 32;
  localparam int unsigned CHAN_PER_REG = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned RES_W = 12;

  // word offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_MODE_LOW = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_MODE_HIGH = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;

  // field positions inside a channel pair
  localparam int unsigned SIGN_BIT_POS = 0;
  localparam int unsigned DIFF_BIT_POS = 1;

  localparam logic [31:0] MODE_LOW_RESET = 32'h0000_0000;
  localparam logic [31:0] MODE_HIGH_RESET = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // first channel dropped in the reduced pin count build
  localparam int unsigned SMALL_PKG_FIRST_ABSENT = 19;

  // mode bits for one channel as the converter core sees them
  typedef struct packed {
    logic differential;
    logic signed_result;
  } chan_mode_t;

  // one raw conversion with its channel number
  typedef struct packed {
    logic [4:0] chan;
    logic [RES_W-1:0] raw;
  } conv_raw_t;

  // formatted conversion result
  typedef struct packed {
    logic [4:0] chan;
    logic is_signed;
    logic [31:0] value;
  } conv_out_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;

  // mask of implemented pair bits in the high register for a given build
  function automatic logic [31:0] high_impl_mask(input logic small_pkg);
    logic [31:0] m;
    m = 32'hFFFF_FFFF;
    if (small_pkg)
      m = 32'hFFFF_FFFF >> (32 - 2 * (SMALL_PKG_FIRST_ABSENT - CHAN_PER_REG));
    return m;
  endfunction

endpackage

// ==== imode_result_fmt.sv ====
// formats a raw conversion as unsigned magnitude or two's complement
`timescale 1ns/1ps
module imode_result_fmt
  import imode_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // raw result and the mode of its channel
  input wire logic in_valid,
  input wire conv_raw_t in_raw,
  input wire chan_mode_t in_mode,
  // formatted result
  output logic out_valid,
  output conv_out_t out_res
);

  logic out_valid_r;
  conv_out_t out_res_r;

  // signed: recentre the midscale code at zero and sign extend
  function automatic logic [31:0] to_twos(input logic [RES_W-1:0] raw);
    logic [RES_W-1:0] flipped;
    flipped = {~raw[RES_W-1], raw[RES_W-2:0]};
    return {{(32-RES_W){flipped[RES_W-1]}}, flipped};
  endfunction

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      out_valid_r <= 1'b0;
    else
      out_valid_r <= in_valid;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      out_res_r <= '0;
    else if (in_valid)
    begin
      out_res_r.chan <= in_raw.chan;
      out_res_r.is_signed <= in_mode.signed_result;
      if (in_mode.signed_result)
        out_res_r.value <= to_twos(in_raw.raw);
      else
        out_res_r.value <= {{(32-RES_W){1'b0}}, in_raw.raw};
    end
  end

  assign out_valid = out_valid_r;
  assign out_res = out_res_r;

endmodule
